// >>> verilog/nvsc_pkg.sv
// Purpose: constants for the host-side store/recall controller
// Assumes: core_clk at 100 MHz
// Notes:   times kept in their own unit, cycle counts derived
package nvsc_pkg;
	localparam int CLK_PERIOD_PS  = 10000;
	localparam int ADDR_W         = 15;
	localparam int DATA_W         = 8;
	localparam int SEQ_LEN        = 6;
	// least times round up, waits use the device maxima
	localparam int BUSY_PULSE_NS  = 15;
	localparam int BUSY_PULSE_CYC = (BUSY_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SRAM_CYC_NS    = 30;
	localparam int SRAM_CYC       = (SRAM_CYC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// recovery cycles so the data synchroniser settles on the strobe value
	localparam int SYNC_CYC       = 2;
	localparam int T_SS_US        = 70;
	localparam int T_RECALL_US    = 120;
	localparam int T_DELAY_US     = 70;
	localparam int T_STORE_US     = 15000;
	localparam int T_PWRUP_US     = 20000;
	localparam int T_RECALL_CYC   = T_RECALL_US * 100;
	localparam int T_STORE_CYC    = (T_STORE_US + T_DELAY_US) * 100;
	localparam int T_PWRUP_CYC    = T_PWRUP_US * 100;
	localparam int T_SS_CYC       = T_SS_US * 100;
	localparam int CNT_W          = 22;
	typedef enum logic [3:0] {
		ST_PWRUP  = 4'b0000,
		ST_IDLE   = 4'b0001,
		ST_RSETUP = 4'b0010,
		ST_RSTRB  = 4'b0011,
		ST_WSETUP = 4'b0100,
		ST_WSTRB  = 4'b0101,
		ST_RECOV  = 4'b0110,
		ST_HSBLOW = 4'b0111,
		ST_HSBWT  = 4'b1000,
		ST_NVWAIT = 4'b1001
	} nvsc_state_t;
endpackage : nvsc_pkg

// >>> verilog/nvsc_sync.sv
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: one clock domain
// Notes:   stage one feeds stage two only
`timescale 1ns/1ps
`default_nettype none
module nvsc_sync #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	input  wire logic             core_clk,  // clock
	input  wire logic             reset,     // sync reset
	input  wire logic [WIDTH-1:0] async_in,  // raw pin
	output logic      [WIDTH-1:0] sync_out   // filtered level
);
	logic [WIDTH-1:0] s1_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	logic [WIDTH-1:0] out_ff;
	// shift chain, output follows once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (reset) begin
			s1_ff  <= INIT;
			s2_ff  <= INIT;
			s3_ff  <= INIT;
			out_ff <= INIT;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					out_ff[i] <= s3_ff[i];
				end
			end
		end
	end
	assign sync_out = out_ff;
endmodule : nvsc_sync
`default_nettype wire

// >>> verilog/nvsc_ctrl.sv
// Purpose: host controller driving a battery-free nonvolatile SRAM
// Assumes: core_clk 100 MHz, reset synchronous active high
// Notes:   reads, writes, six-read soft commands, hardware store pulse
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - chip or write enable is high whenever the address changes
// - each soft step is a chip-enable controlled read
// - six reads in order from the address list, nothing between
// - write enable stays high during all six reads
// - hardware store request drives busy line low at least 15 ns
// - busy line left released during ordinary reads and writes
module nvsc_ctrl #(
	parameter int PWRUP_CYC  = nvsc_pkg::T_PWRUP_CYC,   // power-up recall wait
	parameter int STORE_CYC  = nvsc_pkg::T_STORE_CYC,   // longest store wait
	parameter int RECALL_CYC = nvsc_pkg::T_RECALL_CYC,  // soft command lock-out
	parameter int SS_CYC     = nvsc_pkg::T_SS_CYC       // soft processing / grace
) (
	input  wire logic                        core_clk,        // clock
	input  wire logic                        reset,           // sync reset
	input  wire logic                        req_valid,       // access request
	input  wire logic                        req_write,       // 1 write, 0 read
	input  wire logic [nvsc_pkg::ADDR_W-1:0] req_addr,        // access address
	input  wire logic [nvsc_pkg::DATA_W-1:0] req_wdata,       // write data
	input  wire logic                        soft_valid,      // start six-read command
	input  wire logic [6*nvsc_pkg::ADDR_W-1:0] soft_addrs,    // six addresses, first low
	input  wire logic                        hw_store_req,    // request hardware store
	output logic                             req_ready,       // idle, request taken
	output logic                             rsp_valid,       // read data or write done
	output logic [nvsc_pkg::DATA_W-1:0]      rsp_rdata,       // read data
	output logic                             nv_busy,         // store/recall in progress
	output logic                             chip_en_n,       // chip enable pin
	output logic                             out_en_n,        // output enable pin
	output logic                             wr_en_n,         // write enable pin
	output logic [nvsc_pkg::ADDR_W-1:0]      addr,            // address pins
	output logic [nvsc_pkg::DATA_W-1:0]      dq_out,          // data pins out
	output logic                             dq_oe,           // data pins enable
	input  wire logic [nvsc_pkg::DATA_W-1:0] dq_in,           // data pins in
	output logic                             hw_store_busy_n_out, // busy line out (low)
	output logic                             hw_store_busy_n_oe,  // busy line drive
	input  wire logic                        hw_store_busy_n_in   // busy line level
);
	nvsc_pkg::nvsc_state_t state_ff;
	nvsc_pkg::nvsc_state_t nxt_state;
	logic [nvsc_pkg::CNT_W-1:0]  cnt_ff;
	logic [2:0]                  step_ff;
	logic                        soft_ff;
	logic [6*nvsc_pkg::ADDR_W-1:0] seq_ff;
	logic                        wr_ff;
	logic                        busy_sync;
	logic [nvsc_pkg::DATA_W-1:0] dq_sync;
	logic                        cnt_done;
	logic                        req_ready_ff;
	logic                        rsp_valid_ff;
	logic [nvsc_pkg::DATA_W-1:0] rsp_rdata_ff;
	logic                        nv_busy_ff;
	logic                        chip_en_n_ff;
	logic                        out_en_n_ff;
	logic                        wr_en_n_ff;
	logic [nvsc_pkg::ADDR_W-1:0] addr_ff;
	logic [nvsc_pkg::DATA_W-1:0] dq_out_ff;
	logic                        dq_oe_ff;
	logic                        busy_oe_ff;

	// pin inputs pass the agreement synchroniser
	nvsc_sync #(.WIDTH(1), .INIT(1'b1)) u_busy_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (hw_store_busy_n_in),
		.sync_out (busy_sync)
	);
	nvsc_sync #(.WIDTH(nvsc_pkg::DATA_W), .INIT('0)) u_dq_sync (
		.core_clk (core_clk),
		.reset    (reset),
		.async_in (dq_in),
		.sync_out (dq_sync)
	);

	assign cnt_done = (cnt_ff == '0);

	// sequencer
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			nvsc_pkg::ST_PWRUP:  if (cnt_done) nxt_state = nvsc_pkg::ST_IDLE;
			nvsc_pkg::ST_IDLE: begin
				if (hw_store_req) begin
					nxt_state = nvsc_pkg::ST_HSBLOW;
				end else if (soft_valid) begin
					nxt_state = nvsc_pkg::ST_RSETUP;
				end else if (req_valid && req_write) begin
					nxt_state = nvsc_pkg::ST_WSETUP;
				end else if (req_valid) begin
					nxt_state = nvsc_pkg::ST_RSETUP;
				end
			end
			nvsc_pkg::ST_RSETUP: nxt_state = nvsc_pkg::ST_RSTRB;
			nvsc_pkg::ST_RSTRB:  if (cnt_done) nxt_state = nvsc_pkg::ST_RECOV;
			nvsc_pkg::ST_WSETUP: nxt_state = nvsc_pkg::ST_WSTRB;
			nvsc_pkg::ST_WSTRB:  if (cnt_done) nxt_state = nvsc_pkg::ST_RECOV;
			nvsc_pkg::ST_RECOV: begin
				if (!cnt_done) begin
					nxt_state = nvsc_pkg::ST_RECOV;
				end else if (!soft_ff) begin
					nxt_state = nvsc_pkg::ST_IDLE;
				end else if (step_ff == 3'(nvsc_pkg::SEQ_LEN - 1)) begin
					nxt_state = nvsc_pkg::ST_NVWAIT;
				end else begin
					nxt_state = nvsc_pkg::ST_RSETUP;
				end
			end
			nvsc_pkg::ST_HSBLOW: if (cnt_done) nxt_state = nvsc_pkg::ST_HSBWT;
			nvsc_pkg::ST_HSBWT:  if (cnt_done && busy_sync) nxt_state = nvsc_pkg::ST_IDLE;
			nvsc_pkg::ST_NVWAIT: if (cnt_done && busy_sync) nxt_state = nvsc_pkg::ST_IDLE;
			default:             nxt_state = nvsc_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (reset) state_ff <= nvsc_pkg::ST_PWRUP;
		else       state_ff <= nxt_state;
	end

	// wait counter loaded on each state entry
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_ff <= nvsc_pkg::CNT_W'(PWRUP_CYC);
		end else if (nxt_state != state_ff) begin
			case (nxt_state)
				nvsc_pkg::ST_RSTRB,
				nvsc_pkg::ST_WSTRB:  cnt_ff <= nvsc_pkg::CNT_W'(nvsc_pkg::SRAM_CYC - 1);
				nvsc_pkg::ST_RECOV:  cnt_ff <= nvsc_pkg::CNT_W'(nvsc_pkg::SYNC_CYC);
				nvsc_pkg::ST_HSBLOW: cnt_ff <= nvsc_pkg::CNT_W'(nvsc_pkg::BUSY_PULSE_CYC);
				nvsc_pkg::ST_HSBWT:  cnt_ff <= nvsc_pkg::CNT_W'(STORE_CYC);
				nvsc_pkg::ST_NVWAIT: cnt_ff <= nvsc_pkg::CNT_W'(RECALL_CYC + SS_CYC);
				default:             cnt_ff <= '0;
			endcase
		end else if (!cnt_done) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	// soft command bookkeeping
	always_ff @(posedge core_clk) begin
		if (reset) begin
			soft_ff <= 1'b0;
			step_ff <= '0;
			seq_ff  <= '0;
			wr_ff   <= 1'b0;
		end else if (state_ff == nvsc_pkg::ST_IDLE && nxt_state != nvsc_pkg::ST_IDLE) begin
			soft_ff <= soft_valid && !hw_store_req;
			step_ff <= '0;
			seq_ff  <= soft_addrs;
			wr_ff   <= req_write;
		end else if (state_ff == nvsc_pkg::ST_RECOV && soft_ff && cnt_done) begin
			step_ff <= step_ff + 1'b1;
			seq_ff  <= seq_ff >> nvsc_pkg::ADDR_W;
		end
	end

	// pin drive: address stable while enables low, strobes inside setup
	always_ff @(posedge core_clk) begin
		if (reset) begin
			chip_en_n_ff <= 1'b1;
			out_en_n_ff  <= 1'b1;
			wr_en_n_ff   <= 1'b1;
			addr_ff      <= '0;
			dq_out_ff    <= '0;
			dq_oe_ff     <= 1'b0;
		end else begin
			chip_en_n_ff <= !(nxt_state == nvsc_pkg::ST_RSTRB || nxt_state == nvsc_pkg::ST_WSTRB);
			out_en_n_ff  <= !(nxt_state == nvsc_pkg::ST_RSTRB);
			wr_en_n_ff   <= !(nxt_state == nvsc_pkg::ST_WSTRB);
			dq_oe_ff     <= (nxt_state == nvsc_pkg::ST_WSETUP || nxt_state == nvsc_pkg::ST_WSTRB);
			if (state_ff == nvsc_pkg::ST_IDLE && nxt_state != nvsc_pkg::ST_IDLE) begin
				addr_ff   <= soft_valid ? soft_addrs[nvsc_pkg::ADDR_W-1:0] : req_addr;
				dq_out_ff <= req_wdata;
			end else if (state_ff == nvsc_pkg::ST_RECOV && soft_ff && cnt_done) begin
				addr_ff <= seq_ff[2*nvsc_pkg::ADDR_W-1:nvsc_pkg::ADDR_W];
			end
		end
	end

	// busy line driven only during the store pulse
	always_ff @(posedge core_clk) begin
		if (reset) busy_oe_ff <= 1'b0;
		else       busy_oe_ff <= (nxt_state == nvsc_pkg::ST_HSBLOW);
	end

	// user side status and answers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			req_ready_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_rdata_ff <= '0;
			nv_busy_ff   <= 1'b1;
		end else begin
			req_ready_ff <= (nxt_state == nvsc_pkg::ST_IDLE);
			nv_busy_ff   <= (nxt_state == nvsc_pkg::ST_PWRUP || nxt_state == nvsc_pkg::ST_HSBLOW
				|| nxt_state == nvsc_pkg::ST_HSBWT || nxt_state == nvsc_pkg::ST_NVWAIT);
			rsp_valid_ff <= (state_ff == nvsc_pkg::ST_RECOV) && cnt_done && !soft_ff;
			// read data taken once the synchroniser has settled on the strobe value
			if (state_ff == nvsc_pkg::ST_RECOV && cnt_done && !soft_ff && !wr_ff) begin
				rsp_rdata_ff <= dq_sync;
			end
		end
	end

	assign req_ready           = req_ready_ff;
	assign rsp_valid           = rsp_valid_ff;
	assign rsp_rdata           = rsp_rdata_ff;
	assign nv_busy             = nv_busy_ff;
	assign chip_en_n           = chip_en_n_ff;
	assign out_en_n            = out_en_n_ff;
	assign wr_en_n             = wr_en_n_ff;
	assign addr                = addr_ff;
	assign dq_out              = dq_out_ff;
	assign dq_oe               = dq_oe_ff;
	assign hw_store_busy_n_out = 1'b0;
	assign hw_store_busy_n_oe  = busy_oe_ff;
endmodule : nvsc_ctrl
`default_nettype wire

// >>> sim/nvsc_chk.sv
// Purpose: pin timing checks for the store/recall host controller
// Assumes: one clock, reset synchronous active high
// Notes:   bound to every nvsc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module nvsc_chk #(
	parameter int PWRUP_CYC = 20,  // power-up wait
	parameter int STORE_CYC = 30   // store wait
) (
	input wire logic                        core_clk,            // clock
	input wire logic                        reset,               // sync reset
	input wire logic                        req_ready,           // idle
	input wire logic                        nv_busy,             // store or recall
	input wire logic                        chip_en_n,           // chip enable
	input wire logic                        out_en_n,            // output enable
	input wire logic                        wr_en_n,             // write enable
	input wire logic [nvsc_pkg::ADDR_W-1:0] addr,                // address pins
	input wire logic                        dq_oe,               // data drive
	input wire logic                        hw_store_busy_n_oe,  // busy line pull
	input wire logic                        hw_store_busy_n_in   // busy line level
);
	logic [31:0] quiet_cnt_ff;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// quiet time after power-up and after a store pulse
	always_ff @(posedge core_clk) begin
		if (reset)
			quiet_cnt_ff <= 32'(PWRUP_CYC);
		else if ($fell(hw_store_busy_n_oe))
			quiet_cnt_ff <= 32'(STORE_CYC);
		else if (quiet_cnt_ff != 32'h0)
			quiet_cnt_ff <= quiet_cnt_ff - 32'h1;
	end
	sequence strobe_s; !chip_en_n [*3] ##1 chip_en_n; endsequence
	sequence pulse_s; hw_store_busy_n_oe [*3] ##1 !hw_store_busy_n_oe; endsequence
	a_strobe_three: assert property ($fell(chip_en_n) |-> strobe_s)
		else $error("chip enable strobe length wrong");
	a_pulse_three: assert property ($rose(hw_store_busy_n_oe) |-> pulse_s)
		else $error("store pulse length wrong");
	a_addr_steady: assert property (!$stable(addr) |-> chip_en_n && $past(chip_en_n))
		else $error("address moved while selected");
	a_write_no_out: assert property (!wr_en_n |-> out_en_n && dq_oe)
		else $error("write strobe without data drive");
	a_read_we_high: assert property (!out_en_n |-> wr_en_n && !dq_oe)
		else $error("read strobe with write enable low");
	a_busy_no_acc: assert property (!hw_store_busy_n_in || hw_store_busy_n_oe |-> chip_en_n)
		else $error("access while busy line low");
	a_quiet_wait: assert property (quiet_cnt_ff != 32'h0 |-> chip_en_n && !req_ready)
		else $error("access before wait ended");
	a_idle_free: assert property (req_ready |-> !nv_busy && hw_store_busy_n_in)
		else $error("idle while store or recall runs");
endmodule : nvsc_chk
bind nvsc_ctrl nvsc_chk #(.PWRUP_CYC(PWRUP_CYC), .STORE_CYC(STORE_CYC)) u_chk (
	.core_clk, .reset, .req_ready, .nv_busy, .chip_en_n, .out_en_n, .wr_en_n, .addr,
	.dq_oe, .hw_store_busy_n_oe, .hw_store_busy_n_in);
`default_nettype wire

// >>> sim/nvsc_dev.sv
// Purpose: behavioural nonvolatile SRAM with store and recall
// Assumes: sampled on the falling clock edge, host pins move on the rising
// Notes:   reset stands for the supply below the trigger level
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev #(
	parameter logic [89:0] SEQ     = '0,  // store list, first low
	parameter logic [14:0] RC_LAST = '0,  // last recall address
	parameter int          BUSY_T  = 12,  // store or recall cycles
	parameter int          PWR_T   = 15   // power-up recall cycles
) (
	input  wire logic        core_clk,   // time base
	input  wire logic        reset,      // supply low
	input  wire logic        chip_en_n,  // chip enable
	input  wire logic        out_en_n,   // output enable
	input  wire logic        wr_en_n,    // write enable
	input  wire logic [14:0] addr,       // address
	input  wire logic [7:0]  dq_bus,     // resolved data lines
	input  wire logic        bsy_line,   // resolved busy line
	output logic      [7:0]  dq_dev,     // device data drive
	output logic             bsy_pull    // device pulls busy low
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  nv [0:32767];
	logic [7:0]  alt_ff, wd;
	logic [14:0] wa;
	logic        ce_q, dirty, wp, hw_pend;
	int          lock, step, act;
	wire         rd_drv = !chip_en_n && !out_en_n && wr_en_n && lock == 0;
	assign dq_dev = rd_drv ? mem[addr] : alt_ff;
	initial for (int i = 0; i < 32768; i++) nv[i] = 8'h00;
	// copy between array and shadow, store skipped when clean
	task automatic nv_op(input logic st);
		if (!st || dirty) begin
			for (int i = 0; i < 32768; i++)
				if (st) nv[i] = mem[i]; else mem[i] = nv[i];
			lock = BUSY_T;
			bsy_pull <= st;
		end
		dirty = 0;
		step = 0;
		hw_pend = 0;
	endtask : nv_op
	// pin sampling, command list and lock-out
	always @(negedge core_clk) begin
		alt_ff <= ~dq_bus;  // released lines flip every cycle
		ce_q <= chip_en_n;
		if (reset) begin
			nv_op(1'b0);
			lock = PWR_T;
			act = 0;
			wp = 0;
		end else if (lock != 0) begin
			lock = lock - 1;
			if (lock == 0) bsy_pull <= 1'b0;
		end else if (act != 0) begin
			act = act - 1;
			if (act == 0) nv_op(step == 6);
		end else begin
			if (!bsy_line) hw_pend = 1;
			if (hw_pend && chip_en_n) nv_op(1'b1);
			if (ce_q && !chip_en_n) begin
				if (wr_en_n && addr == SEQ[step*15+:15]) step++;
				else if (wr_en_n && step == 5 && addr == RC_LAST) step = 7;
				else step = int'(wr_en_n && addr == SEQ[14:0]);
				if (step >= 6) act = 4;
			end
			if (!chip_en_n && !wr_en_n) begin
				wa = addr;
				wd = dq_bus;
				wp = 1;
			end else if (wp && chip_en_n) begin
				mem[wa] = wd;
				dirty = 1;
				wp = 0;
			end
		end
	end
endmodule : nvsc_dev
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench for the store/recall host controller
// Assumes: 100 MHz clock, inputs driven on the falling edge
// Notes:   shortened wait counts, device model on the far side
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [89:0] SEQ = {15'h6789, 15'h5678, 15'h4567, 15'h3456, 15'h2345, 15'h1234};
	localparam logic [89:0] RCL = {15'h0abc, SEQ[74:0]};
	logic        core_clk = 0, reset = 1, req_valid = 0, req_write = 0, soft_valid = 0;
	logic        hw_store_req = 0, req_ready, rsp_valid, nv_busy, chip_en_n, out_en_n;
	logic        wr_en_n, dq_oe, bsy_out, bsy_oe, bsy_pull;
	logic [14:0] req_addr = '0, addr;
	logic [7:0]  req_wdata = '0, rsp_rdata, dq_out, dq_dev;
	logic [89:0] soft_addrs = '0;
	int          error_cnt = 0, n_compared = 0, pull_cyc = 0;
	wire [7:0]   dq_bus = dq_oe ? dq_out : dq_dev;
	wire         bsy_line = (bsy_oe ? bsy_out : 1'b1) & ~bsy_pull;  // pull-up
	nvsc_ctrl #(.PWRUP_CYC(20), .STORE_CYC(30), .RECALL_CYC(20), .SS_CYC(10)) u_dut (
		.core_clk, .reset, .req_valid, .req_write, .req_addr, .req_wdata, .soft_valid,
		.soft_addrs, .hw_store_req, .req_ready, .rsp_valid, .rsp_rdata, .nv_busy,
		.chip_en_n, .out_en_n, .wr_en_n, .addr, .dq_out, .dq_oe, .dq_in(dq_bus),
		.hw_store_busy_n_out(bsy_out), .hw_store_busy_n_oe(bsy_oe), .hw_store_busy_n_in(bsy_line));
	nvsc_dev #(.SEQ(SEQ), .RC_LAST(RCL[89:75])) u_dev (.core_clk, .reset, .chip_en_n,
		.out_en_n, .wr_en_n, .addr, .dq_bus, .bsy_line, .dq_dev, .bsy_pull);
	always #5 core_clk = ~core_clk;
	always @(negedge core_clk) if (bsy_pull) pull_cyc++;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	task automatic wait_ready();
		int i;
		for (i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge core_clk);
		if (i == 3000) begin
			error_cnt++;
			stop_test();
		end
	endtask : wait_ready
	task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int i;
		wait_ready();
		req_valid = 1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		@(negedge core_clk);
		req_valid = 0;
		for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge core_clk);
		if (i == 20) begin
			error_cnt++;
			stop_test();
		end
		q = rsp_rdata;
	endtask : access
	// store pulse or six-read command, then busy mid-way and idle again
	task automatic command(input logic hw, input logic [89:0] seq);
		wait_ready();
		hw_store_req = hw;
		soft_valid = !hw;
		soft_addrs = seq;
		@(negedge core_clk);
		hw_store_req = 0;
		soft_valid = 0;
		repeat (hw ? 8 : 45) @(negedge core_clk);
		check({7'h0, req_ready}, 8'h00);
		check({7'h0, nv_busy}, 8'h01);
		wait_ready();
	endtask : command
	task automatic t_rw();
		logic [7:0] q;
		access(1, 15'h0000, 8'ha5, q);
		access(1, 15'h7fff, 8'h5a, q);
		access(0, 15'h0000, 8'h00, q);
		check(q, 8'ha5);
		access(0, 15'h7fff, 8'h00, q);
		check(q, 8'h5a);
		$display("test rw done");
	endtask : t_rw
	task automatic t_soft();
		logic [7:0] q;
		access(1, 15'h0100, 8'h3c, q);
		command(0, SEQ);
		access(1, 15'h0100, 8'hc3, q);
		access(0, 15'h0100, 8'h00, q);
		check(q, 8'hc3);
		command(0, RCL);
		access(0, 15'h0100, 8'h00, q);
		check(q, 8'h3c);
		$display("test soft done");
	endtask : t_soft
	task automatic t_hw();
		logic [7:0] q;
		int p;
		access(1, 15'h0200, 8'h77, q);
		p = pull_cyc;
		command(1, '0);
		check({7'h0, pull_cyc > p}, 8'h01);
		access(1, 15'h0200, 8'h11, q);
		command(0, RCL);
		access(0, 15'h0200, 8'h00, q);
		check(q, 8'h77);
		p = pull_cyc;
		command(1, '0);
		check({7'h0, pull_cyc == p}, 8'h01);
		$display("test hw done");
	endtask : t_hw
	initial begin
		repeat (4) @(negedge core_clk);
		reset = 0;
		check({7'h0, req_ready}, 8'h00);
		t_rw();
		t_soft();
		t_hw();
		stop_test();
	end
endmodule : tb
`default_nettype wire
